/* File: lcdl_host_model.sv */
// Host controller model: serial clock, serial data and latch strobe
`timescale 1ns/10ps
`default_nettype none

module lcdl_host_model (
	output logic serial_clock,
	output logic serial_data_in,
	output logic latch_strobe
);
	// ---------------------------------------------------------------
	// Link driving
	// ---------------------------------------------------------------
	initial begin
		serial_clock = 1'b0;
		serial_data_in = 1'b0;
		latch_strobe = 1'b0;
	end

	// Odd offset keeps the link edges away from the system clock edges
	task automatic idle_clocks(input int n);
		#7;
		repeat (n) begin
			#40 serial_clock = 1'b1;
			#40 serial_clock = 1'b0;
		end
	endtask

	task automatic send(input logic [768:0] w);
		#7;
		for (int i = 768; i >= 0; i--) begin
			serial_data_in = w[i];
			#40 serial_clock = 1'b1;
			#40 serial_clock = 1'b0;
		end
		// Released line shows the inverse, never a stale level
		serial_data_in = ~w[0];
		#40 latch_strobe = 1'b1;
		// Clock stays still well past the synchronised latch rise
		#240 latch_strobe = 1'b0;
		#80;
	endtask
endmodule

`default_nettype wire

/* File: lcdl_link.sv */
// Serial-clock side of the block: the common shift register
`timescale 1ns/10ps
`default_nettype none

module lcdl_link (
	input wire logic serial_clock,
	input wire logic aresetn,
	input wire logic serial_data_in,
	output logic serial_data_out,
	output logic [lcdl_pkg::SHIFT_W-1:0] shift_word
);
	import lcdl_pkg::*;

	typedef struct packed {
		logic rst_meta;
		logic rst_sync;
		logic [SHIFT_W-1:0] sh;
	} lcdl_link_state_t;

	lcdl_link_state_t s_ff;
	lcdl_link_state_t nxt_s;

	always_comb begin
		nxt_s = s_ff;
		nxt_s.rst_meta = aresetn;
		nxt_s.rst_sync = s_ff.rst_meta;
		// Reset only takes hold while the serial clock runs
		if (!s_ff.rst_sync) begin
			nxt_s.sh = '0;
		end else begin
			nxt_s.sh = {s_ff.sh[SHIFT_W-2:0], serial_data_in};
		end
	end

	always_ff @(posedge serial_clock) begin
		s_ff <= nxt_s;
	end

	assign serial_data_out = s_ff.sh[SHIFT_W-1];
	assign shift_word = s_ff.sh;

	AST_SHIFT_STEP: assert property (@(posedge serial_clock) disable iff (!s_ff.rst_sync)
		##1 s_ff.sh == {$past(s_ff.sh[SHIFT_W-2:0]), $past(serial_data_in)})
		else $error("shift register did not advance by one bit");

endmodule

`default_nettype wire

/* File: lcdl_pkg.sv */
// Constants and carrier types for the LED control data latch block
package lcdl_pkg;

	// ---------------------------------------------------------------
	// Widths and layout
	// ---------------------------------------------------------------
	localparam int SHIFT_W = 769;
	localparam int CTRL_W = 371;
	localparam int DC_W = 336;
	localparam int DC_BITS = 7;
	localparam int NUM_OUT = 48;
	localparam int KEY_LSB = 760;
	localparam logic [7:0] CTRL_KEY = 8'h96;
	localparam logic [6:0] CODE_MAX = 7'h7f;

	// ---------------------------------------------------------------
	// Grayscale period and current scaling (per mille)
	// ---------------------------------------------------------------
	localparam int GS_CNT_W = 17;
	localparam int unsigned GS_PERIOD_DEF = 65536;
	localparam logic [9:0] DC_FLOOR_PM = 10'h106;
	localparam logic [9:0] BC_FLOOR_PM = 10'h064;
	localparam logic [9:0] FULL_PM = 10'h3e8;

	// ---------------------------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_DC = 12'h040;
	localparam logic [11:0] OFF_STATUS = 12'h080;
	localparam logic [11:0] OFF_GSCNT = 12'h084;
	localparam logic [11:0] OFF_QSEL = 12'h088;
	localparam logic [11:0] OFF_QRES = 12'h08c;
	localparam logic [11:0] OFF_CMD = 12'h090;
	localparam logic [3:0] CTRL_WORDS = 4'hc;
	localparam logic [3:0] DC_WORDS = 4'hb;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ---------------------------------------------------------------
	// Control word layout, msb first
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [2:0] blue;
		logic [2:0] green;
		logic [2:0] red;
	} lcdl_mc_t;

	typedef struct packed {
		logic short_thr_sel;
		logic pwm_mode_sel;
		logic auto_refresh;
		logic timing_reset;
		logic display_repeat;
		logic [6:0] bc_blue;
		logic [6:0] bc_green;
		logic [6:0] bc_red;
		lcdl_mc_t mc;
		logic [DC_W-1:0] dc;
	} lcdl_ctrl_t;

endpackage

/* File: lcdl_top.sv */
// Control data latches with shift register, refresh and register access
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Keep a 371-bit control storage word
// - Latch rise with top bit set loads control
// - Auto refresh copies dot correction after 65536
// - No auto refresh copies at grayscale write
// - Working dot correction: 48 seven-bit values
// - Dot correction scales 26.2 to 100 percent
// - Fields packed channel order, red green blue
// - Full codes give full group current
// - Maximum current changes after two equal writes
// - Maximum current clears to zero at reset
// - Maximum current fields at bits 344-336
// - Control load also needs key 96h
// - Shift register shifts toward top bit
// - Brightness fields at bits 365-345
// - Bit 368 selects deferred dot correction copy
module lcdl_top #(
	parameter int unsigned GS_PERIOD = lcdl_pkg::GS_PERIOD_DEF
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic serial_clock,
	input wire logic serial_data_in,
	output logic serial_data_out,
	input wire logic latch_strobe,
	input wire logic grayscale_clock,
	input wire logic [lcdl_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [lcdl_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [2:0] max_current_red,
	output logic [2:0] max_current_green,
	output logic [2:0] max_current_blue,
	output logic [6:0] brightness_red,
	output logic [6:0] brightness_green,
	output logic [6:0] brightness_blue,
	output logic auto_refresh_enable,
	output logic display_repeat_en,
	output logic timing_reset_en,
	output logic pwm_mode_sel,
	output logic short_thr_sel,
	output logic [lcdl_pkg::DC_W-1:0] dot_corr_working
);
	import lcdl_pkg::*;

	localparam logic [GS_CNT_W-1:0] GS_LAST = GS_CNT_W'(GS_PERIOD - 1);
	localparam int PAD_W = 384;

	typedef struct packed {
		logic strobe_meta;
		logic strobe_sync;
		logic strobe_prev;
		logic gs_meta;
		logic gs_sync;
		logic gs_prev;
		lcdl_ctrl_t cw;
		lcdl_mc_t mc_cand;
		logic [DC_W-1:0] dc_work;
		logic armed;
		logic [GS_CNT_W-1:0] gs_cnt;
		logic [5:0] q_sel;
		logic [9:0] q_dc_pm;
		logic [9:0] q_tot_pm;
		logic aw_got;
		logic w_got;
		logic [ADDR_W-1:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} lcdl_state_t;

	lcdl_state_t s_ff;
	lcdl_state_t nxt_s;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [9:0] scale_pm(input logic [6:0] code,
			input logic [9:0] floor_pm);
		logic [19:0] span;
		span = 20'(FULL_PM - floor_pm) * 20'(code);
		return floor_pm + 10'(span / 20'(CODE_MAX));
	endfunction

	function automatic logic [9:0] mix_pm(input logic [9:0] a,
			input logic [9:0] b);
		logic [19:0] prod;
		prod = 20'(a) * 20'(b);
		return 10'(prod / 20'(FULL_PM));
	endfunction

	function automatic logic [6:0] bc_of(input lcdl_ctrl_t c,
			input logic [5:0] idx);
		logic [5:0] grp;
		grp = idx % 6'h3;
		case (grp)
			6'h0: return c.bc_red;
			6'h1: return c.bc_green;
			default: return c.bc_blue;
		endcase
	endfunction

	function automatic logic [31:0] word_of(input logic [PAD_W-1:0] v,
			input logic [3:0] i);
		return v[i*32 +: 32];
	endfunction

	function automatic logic same_word(input logic [ADDR_W-1:0] a,
			input logic [ADDR_W-1:0] b);
		return a[ADDR_W-1:2] == b[ADDR_W-1:2];
	endfunction

	// ---------------------------------------------------------------
	// Shift register on the serial clock
	// ---------------------------------------------------------------
	logic [SHIFT_W-1:0] shift_word;

	lcdl_link u_link (
		.serial_clock(serial_clock),
		.aresetn(aresetn),
		.serial_data_in(serial_data_in),
		.serial_data_out(serial_data_out),
		.shift_word(shift_word)
	);

	// ---------------------------------------------------------------
	// Latch decode
	// ---------------------------------------------------------------
	// The host holds the serial clock still around a latch pulse, so
	// the shift word is quiet when the synchronised edge samples it.
	logic strobe_rise;
	logic gs_rise;
	logic ctl_wr;
	logic gs_wr;
	lcdl_ctrl_t new_cw;
	logic [6:0] q_dc;

	assign strobe_rise = s_ff.strobe_sync & ~s_ff.strobe_prev;
	assign gs_rise = s_ff.gs_sync & ~s_ff.gs_prev;
	assign ctl_wr = strobe_rise & shift_word[SHIFT_W-1]
		& (shift_word[KEY_LSB +: 8] == CTRL_KEY);
	assign gs_wr = strobe_rise & ~shift_word[SHIFT_W-1];
	assign new_cw = lcdl_ctrl_t'(shift_word[CTRL_W-1:0]);
	assign q_dc = s_ff.dc_work[s_ff.q_sel*DC_BITS +: DC_BITS];

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		logic [31:0] rd;
		logic [1:0] rr;
		logic [ADDR_W-1:0] ra;
		logic [9:0] dc_pm;
		rd = '0;
		rr = RESP_OKAY;
		ra = s_axi_araddr;
		dc_pm = scale_pm(q_dc, DC_FLOOR_PM);
		nxt_s = s_ff;

		nxt_s.strobe_meta = latch_strobe;
		nxt_s.strobe_sync = s_ff.strobe_meta;
		nxt_s.strobe_prev = s_ff.strobe_sync;
		nxt_s.gs_meta = grayscale_clock;
		nxt_s.gs_sync = s_ff.gs_meta;
		nxt_s.gs_prev = s_ff.gs_sync;

		// Query of one channel's scaled current
		nxt_s.q_dc_pm = dc_pm;
		nxt_s.q_tot_pm = mix_pm(dc_pm,
			scale_pm(bc_of(s_ff.cw, s_ff.q_sel), BC_FLOOR_PM));

		// Write channel
		if (s_ff.awready && s_axi_awvalid) begin
			nxt_s.aw_got = 1'b1;
			nxt_s.aw_addr = s_axi_awaddr;
		end
		if (s_ff.wready && s_axi_wvalid) begin
			nxt_s.w_got = 1'b1;
			nxt_s.w_data = s_axi_wdata;
			nxt_s.w_strb = s_axi_wstrb;
		end
		if (s_ff.aw_got && s_ff.w_got && !s_ff.bvalid) begin
			nxt_s.bvalid = 1'b1;
			nxt_s.bresp = RESP_OKAY;
			if (same_word(s_ff.aw_addr, OFF_QSEL)) begin
				if (s_ff.w_strb[0] && s_ff.w_data[5:0] < 6'(NUM_OUT)) begin
					nxt_s.q_sel = s_ff.w_data[5:0];
				end
			end else if (same_word(s_ff.aw_addr, OFF_CMD)) begin
				// Software drop of a pending deferred copy
				if (s_ff.w_strb[0] && s_ff.w_data[0]) begin
					nxt_s.armed = 1'b0;
				end
			end else begin
				nxt_s.bresp = RESP_SLVERR;
			end
		end
		if (s_ff.bvalid && s_axi_bready) begin
			nxt_s.bvalid = 1'b0;
			nxt_s.aw_got = 1'b0;
			nxt_s.w_got = 1'b0;
		end

		// Read channel
		if (ra[ADDR_W-1:6] == OFF_CTRL[ADDR_W-1:6] && ra[5:2] < CTRL_WORDS) begin
			rd = word_of(PAD_W'(s_ff.cw), ra[5:2]);
		end else if (ra[ADDR_W-1:6] == OFF_DC[ADDR_W-1:6] && ra[5:2] < DC_WORDS) begin
			rd = word_of(PAD_W'(s_ff.dc_work), ra[5:2]);
		end else if (same_word(ra, OFF_STATUS)) begin
			rd = {13'h0, s_ff.armed, s_ff.mc_cand, s_ff.cw.mc};
		end else if (same_word(ra, OFF_GSCNT)) begin
			rd = 32'(s_ff.gs_cnt);
		end else if (same_word(ra, OFF_QSEL)) begin
			rd = {26'h0, s_ff.q_sel};
		end else if (same_word(ra, OFF_QRES)) begin
			rd = {12'h0, s_ff.q_tot_pm, s_ff.q_dc_pm};
		end else if (!same_word(ra, OFF_CMD)) begin
			rr = RESP_SLVERR;
		end
		if (s_ff.arready && s_axi_arvalid) begin
			nxt_s.rvalid = 1'b1;
			nxt_s.rdata = rd;
			nxt_s.rresp = rr;
		end
		if (s_ff.rvalid && s_axi_rready) begin
			nxt_s.rvalid = 1'b0;
		end

		// Control write; maximum current needs two equal writes
		if (ctl_wr) begin
			nxt_s.cw = new_cw;
			nxt_s.cw.mc = s_ff.cw.mc;
			if (new_cw.mc == s_ff.mc_cand) begin
				nxt_s.cw.mc = new_cw.mc;
			end
			nxt_s.mc_cand = new_cw.mc;
		end

		// Deferred copy counts synchronised grayscale edges
		if (s_ff.armed && gs_rise) begin
			if (s_ff.gs_cnt == GS_LAST) begin
				nxt_s.dc_work = s_ff.cw.dc;
				nxt_s.armed = 1'b0;
				nxt_s.gs_cnt = '0;
			end else begin
				nxt_s.gs_cnt = s_ff.gs_cnt + 1'b1;
			end
		end
		// Grayscale write wins over a software drop in the same cycle
		if (gs_wr) begin
			nxt_s.gs_cnt = '0;
			if (s_ff.cw.auto_refresh) begin
				nxt_s.armed = 1'b1;
			end else begin
				nxt_s.dc_work = s_ff.cw.dc;
				nxt_s.armed = 1'b0;
			end
		end

		nxt_s.awready = !nxt_s.aw_got;
		nxt_s.wready = !nxt_s.w_got;
		nxt_s.arready = !nxt_s.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign s_axi_awready = s_ff.awready;
	assign s_axi_wready = s_ff.wready;
	assign s_axi_bvalid = s_ff.bvalid;
	assign s_axi_bresp = s_ff.bresp;
	assign s_axi_arready = s_ff.arready;
	assign s_axi_rvalid = s_ff.rvalid;
	assign s_axi_rdata = s_ff.rdata;
	assign s_axi_rresp = s_ff.rresp;
	assign max_current_red = s_ff.cw.mc.red;
	assign max_current_green = s_ff.cw.mc.green;
	assign max_current_blue = s_ff.cw.mc.blue;
	assign brightness_red = s_ff.cw.bc_red;
	assign brightness_green = s_ff.cw.bc_green;
	assign brightness_blue = s_ff.cw.bc_blue;
	assign auto_refresh_enable = s_ff.cw.auto_refresh;
	assign display_repeat_en = s_ff.cw.display_repeat;
	assign timing_reset_en = s_ff.cw.timing_reset;
	assign pwm_mode_sel = s_ff.cw.pwm_mode_sel;
	assign short_thr_sel = s_ff.cw.short_thr_sel;
	assign dot_corr_working = s_ff.dc_work;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	AST_CTRL_LOAD: assert property (
		ctl_wr |=> s_ff.cw.dc == $past(shift_word[DC_W-1:0])
			&& brightness_blue == $past(shift_word[365:359])
			&& auto_refresh_enable == $past(shift_word[368]))
		else $error("control word not loaded from shift register");

	AST_KEY_GUARD: assert property (
		strobe_rise && shift_word[SHIFT_W-1]
			&& shift_word[KEY_LSB +: 8] != CTRL_KEY
		|=> $stable(s_ff.cw))
		else $error("control word changed without key");

	AST_MC_HOLD: assert property (
		ctl_wr && new_cw.mc != s_ff.mc_cand |=> $stable(s_ff.cw.mc))
		else $error("maximum current changed on a single write");

	AST_MC_COMMIT: assert property (
		ctl_wr && new_cw.mc == s_ff.mc_cand
		|=> max_current_green == $past(shift_word[341:339])
			&& s_ff.mc_cand == s_ff.cw.mc)
		else $error("repeated maximum current not committed");

	AST_MC_RESET: assert property (
		!$past(aresetn) |-> s_ff.cw.mc == '0 && s_ff.mc_cand == '0)
		else $error("maximum current not zero after reset");

	AST_DC_NOW: assert property (
		gs_wr && !s_ff.cw.auto_refresh
		|=> dot_corr_working == $past(s_ff.cw.dc) && !s_ff.armed)
		else $error("immediate dot correction copy missing");

	AST_DC_ARM: assert property (
		gs_wr && s_ff.cw.auto_refresh
		|=> s_ff.armed && s_ff.gs_cnt == '0 && $stable(s_ff.dc_work))
		else $error("deferred copy not armed");

	AST_DC_FIRE: assert property (
		s_ff.armed && gs_rise && s_ff.gs_cnt == GS_LAST && !gs_wr
		|=> !s_ff.armed && s_ff.dc_work == $past(s_ff.cw.dc))
		else $error("deferred copy missed its grayscale edge");

	AST_DC_QUIET: assert property (
		!(s_ff.armed && gs_rise) && !gs_wr |=> $stable(s_ff.dc_work))
		else $error("working dot correction changed without cause");

	AST_DC_FLOOR: assert property (
		q_dc == '0 |=> s_ff.q_dc_pm == DC_FLOOR_PM)
		else $error("zero code not at floor current");

	AST_FULL_SCALE: assert property (
		q_dc == CODE_MAX && bc_of(s_ff.cw, s_ff.q_sel) == CODE_MAX
		|=> s_ff.q_tot_pm == FULL_PM)
		else $error("full codes not at full current");

	AST_READ_ANSWER: assert property (
		s_ff.arready && s_axi_arvalid |=> s_ff.rvalid [*1] ##0 !s_ff.arready)
		else $error("read not answered at next edge");

	COV_MC_COMMIT: cover property (ctl_wr && new_cw.mc == s_ff.mc_cand);
	COV_DC_FIRE: cover property (s_ff.armed && gs_rise && s_ff.gs_cnt == GS_LAST);
	COV_DC_NOW: cover property (gs_wr && !s_ff.cw.auto_refresh);
	COV_AXI_READ: cover property (s_ff.rvalid && s_axi_rready);

endmodule

`default_nettype wire

/* File: test_led_control_data_latches.sv */
// Self-checking bench for the LED control data latches
`timescale 1ns/10ps
`default_nettype none

module test_led_control_data_latches;
	import lcdl_pkg::*;
	localparam int unsigned GSP = 8;
	logic aclk = 1'b0, aresetn = 1'b0, gs_clk = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [11:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = 4'hf;
	wire logic sclk, sdi, strobe, sdo, awready, wready, bvalid, arready, rvalid;
	wire logic are, drp, tmr, pwm, sth;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [2:0] mc_r, mc_g, mc_b;
	wire logic [6:0] bc_r, bc_g, bc_b;
	wire logic [DC_W-1:0] dcw;
	int err_count = 0, checks = 0, cyc = 0;
	lcdl_ctrl_t c1, c2;
	logic [31:0] d;
	logic [1:0] r;

	always #20 aclk = ~aclk;

	lcdl_host_model u_lcdl_host_model (.serial_clock(sclk), .serial_data_in(sdi),
		.latch_strobe(strobe));

	lcdl_top #(.GS_PERIOD(GSP)) u_lcdl_top (.aclk(aclk), .aresetn(aresetn),
		.serial_clock(sclk), .serial_data_in(sdi), .serial_data_out(sdo),
		.latch_strobe(strobe), .grayscale_clock(gs_clk),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.max_current_red(mc_r), .max_current_green(mc_g), .max_current_blue(mc_b),
		.brightness_red(bc_r), .brightness_green(bc_g), .brightness_blue(bc_b),
		.auto_refresh_enable(are), .display_repeat_en(drp), .timing_reset_en(tmr),
		.pwm_mode_sel(pwm), .short_thr_sel(sth), .dot_corr_working(dcw));

	// ---------------------------------------------------------------
	// Checking and closing
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [370:0] seen, input logic [370:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task final_report;
		$display("mismatches %0d comparisons %0d", err_count, checks);
		if (err_count == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Whole run needs about 12700 cycles
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_count++;
			final_report;
		end
	end

	// ---------------------------------------------------------------
	// Bus cycles and stimulus helpers
	// ---------------------------------------------------------------
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic axi_rd(input logic [11:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic gs_pulses(input int n);
		repeat (n) begin
			repeat (3) @(posedge aclk);
			gs_clk <= 1'b1;
			repeat (3) @(posedge aclk);
			gs_clk <= 1'b0;
		end
		repeat (6) @(posedge aclk);
	endtask

	function automatic lcdl_ctrl_t rnd_ctrl(input logic ar);
		logic [370:0] v;
		lcdl_ctrl_t c;
		for (int i = 0; i < 12; i++) v = {v[338:0], $urandom};
		c = v;
		c.auto_refresh = ar;
		c.dc[6:0] = CODE_MAX;
		c.dc[27:21] = 7'h00;
		c.bc_red = CODE_MAX;
		return c;
	endfunction

	function automatic logic [768:0] cframe(input lcdl_ctrl_t c, input logic [7:0] k);
		return {1'b1, k, 389'(0), c};
	endfunction

	function automatic logic [768:0] gframe();
		return {1'b0, {24{$urandom}}};
	endfunction

	// Readback shows the committed maximum current, not the one just written
	function automatic logic [31:0] cw_word(input lcdl_ctrl_t c,
			input logic [8:0] mc, input int i);
		c.mc = mc;
		return 32'(c >> (32 * i));
	endfunction

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		void'($urandom(42514));
		// Reset must also see link edges for the shift register
		u_lcdl_host_model.idle_clocks(4);
		@(posedge aclk);
		aresetn <= 1'b1;
		u_lcdl_host_model.idle_clocks(2);
		chk("mc reset", 371'({mc_b, mc_g, mc_r}), 371'(0));
		c1 = rnd_ctrl(1'b0);
		c1.mc = 9'h0d5;
		u_lcdl_host_model.send(cframe(c1, CTRL_KEY));
		repeat (8) @(posedge aclk);
		chk("serial_data_out", 371'(sdo), 371'(1));
		chk("mc single", 371'({mc_b, mc_g, mc_r}), 371'(0));
		chk("bc", 371'({bc_b, bc_g, bc_r}), 371'(c1[365:345]));
		chk("fc", 371'({sth, pwm, are, tmr, drp}), 371'(c1[370:366]));
		for (int i = 0; i < 12; i++) begin
			axi_rd(12'(4 * i));
			chk("ctrl word", 371'(d), 371'(cw_word(c1, 9'h0, i)));
		end
		u_lcdl_host_model.send(cframe(c1, CTRL_KEY));
		repeat (8) @(posedge aclk);
		chk("mc twice", 371'({mc_b, mc_g, mc_r}), 371'(c1.mc));
		c2 = rnd_ctrl(1'b1);
		u_lcdl_host_model.send(cframe(c2, CTRL_KEY ^ 8'h01));
		repeat (8) @(posedge aclk);
		chk("bad key", 371'({bc_b, bc_g, bc_r}), 371'(c1[365:345]));
		// Settings are in place before the first grayscale write
		u_lcdl_host_model.send(gframe());
		repeat (8) @(posedge aclk);
		chk("dc now", 371'(dcw), 371'(c1.dc));
		for (int i = 0; i < 11; i++) begin
			axi_rd(OFF_DC + 12'(4 * i));
			chk("dc word", 371'(d), 371'(32'(c1.dc >> (32 * i))));
		end
		axi_wr(OFF_QSEL, 32'h0);
		chk("qsel resp", 371'(r), 371'(RESP_OKAY));
		axi_rd(OFF_QRES);
		chk("full total", 371'(d[19:10]), 371'(FULL_PM));
		chk("full dc", 371'(d[9:0]), 371'(FULL_PM));
		axi_wr(OFF_QSEL, 32'h3);
		axi_rd(OFF_QRES);
		chk("floor dc", 371'(d[9:0]), 371'(DC_FLOOR_PM));
		axi_wr(OFF_QSEL, 32'h30);
		axi_rd(OFF_QSEL);
		chk("qsel kept", 371'(d), 371'(3));
		u_lcdl_host_model.send(cframe(c2, CTRL_KEY));
		repeat (8) @(posedge aclk);
		chk("refresh on", 371'(are), 371'(1));
		chk("mc held", 371'({mc_b, mc_g, mc_r}), 371'(c2.mc == c1.mc ? c2.mc : c1.mc));
		u_lcdl_host_model.send(gframe());
		repeat (8) @(posedge aclk);
		axi_rd(OFF_STATUS);
		chk("armed", 371'(d[18]), 371'(1));
		chk("candidate", 371'(d[17:9]), 371'(c2.mc));
		gs_pulses(GSP - 1);
		chk("dc held", 371'(dcw), 371'(c1.dc));
		gs_pulses(1);
		chk("dc deferred", 371'(dcw), 371'(c2.dc));
		// A software drop cancels a pending deferred copy
		c1.auto_refresh = 1'b1;
		u_lcdl_host_model.send(cframe(c1, CTRL_KEY));
		u_lcdl_host_model.send(gframe());
		gs_pulses(3);
		axi_rd(OFF_GSCNT);
		chk("gs count", 371'(d), 371'(3));
		axi_wr(OFF_CMD, 32'h1);
		chk("cmd resp", 371'(r), 371'(RESP_OKAY));
		gs_pulses(GSP);
		axi_rd(OFF_STATUS);
		chk("dropped", 371'(d[18]), 371'(0));
		chk("dc kept", 371'(dcw), 371'(c2.dc));
		axi_rd(12'h0fc);
		chk("unmapped rd", 371'(r), 371'(RESP_SLVERR));
		chk("unmapped data", 371'(d), 371'(0));
		axi_wr(12'h0fc, $urandom);
		chk("unmapped wr", 371'(r), 371'(RESP_SLVERR));
		final_report;
	end
endmodule

`default_nettype wire
